/* hw/icm_channel.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: Mode 0 output low from control word until zero, then high until rewritten.
// R2: Gate high enables, low suspends counting in modes 0,2,3,4; no output effect 0,4.
// R3: Mode 0 count loads undecremented on next pulse; output rises N+1 pulses later.
// R4: Mode 0 first byte of two forces output low at once; counting continues only after wrap.
// R5: Mode 0 low byte before wrap halts counter; after wrap counting continues.
// R6: Mode 0 count written with gate low still loads on next pulse.
// R7: Mode 1 output high, low pulse after trigger until zero, high again.
// R8: Mode 1 each trigger reloads count next pulse, giving N-cycle low pulse.
// R9: Mode 1 new count affects pulse only after the next trigger.
// R10: Mode 2 loads next pulse, output low one pulse at count 1, reloads.
// R11: Modes 2,3 gate low while output low sets output high at once.
// R12: Modes 2,3 trigger reloads count on next pulse, restarting period.
// R13: Mode 2 new count waits for trigger or end of current cycle.
// R14: Host never programs 1 in modes 2,3; zero means full range.
// R15: Mode 3 square wave of period N, high first half.
// R16: Mode 3 even count loads then steps by two, toggles and reloads.
// R17: Mode 3 odd count loads N-1, high (N+1)/2 and low (N-1)/2 pulses.
// R18: Mode 3 new count takes effect at half-cycle end or after trigger.
// R19: Mode 4 count write loads next pulse, one-pulse low strobe after N+1.
// R20: Mode 4 first byte leaves counting alone; second byte reloads next pulse.
// R21: Mode 5 trigger loads next pulse, strobe N+1 pulses after each trigger.
// R22: Mode 5 new count used only after a later trigger.
// R23: Gate sampled on counter clock rise; trigger flag caught and cleared there.
// R24: Loads and decrements happen on counter clock fall.
// R25: Modes 0,1,4,5 wrap past zero; modes 2,3 reload.
// R26: Control word write resets channel logic and sets output initial level.
// R27: Control logic supplies mode, BCD choice, byte access and byte strobes.
module icm_channel
	import icm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clk_en,
	input wire logic ctr_clk,
	input wire logic gate,
	input wire logic ctrl_wr,
	input wire logic [2:0] mode_in,
	input wire logic bcd_in,
	input wire logic [1:0] bytes_in,
	input wire logic lsb_wr,
	input wire logic msb_wr,
	input wire logic [7:0] wr_data,
	output logic timer_out,
	output logic [15:0] count_value,
	output logic null_count
);
	import icm_pkg::*;

	logic rst_meta;
	logic rst_n;
	logic ctr_q;
	logic gate_q;
	logic gate_s;
	logic trig_ff;
	logic trig_s;
	logic [2:0] cnt_mode;
	logic bcd_sel;
	logic [1:0] bytes_sel;
	logic [15:0] count_holding_register;
	logic lsb_pending;
	logic have_count;
	logic [15:0] ce;
	logic load_pending;
	logic counting;
	logic halt;
	logic wrapped;
	logic fired;
	logic odd_wait;
	logic rise_ev;
	logic fall_ev;
	logic count_done;
	logic gate_rise;

	// Decrement by one, binary or BCD; zero wraps to the top of the range
	function automatic logic [15:0] icm_dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic borrow;
		r = v;
		borrow = 1'b1;
		if (!bcd)
			r = v - COUNT_ONE;
		else
			for (int i = 0; i < 4; i++)
			begin
				if (borrow)
				begin
					if (v[4*i +: 4] == 4'h0)
						r[4*i +: 4] = BCD_NINE;
					else
					begin
						r[4*i +: 4] = v[4*i +: 4] - 4'h1;
						borrow = 1'b0;
					end
				end
			end
		return r;
	endfunction : icm_dec

	// Reset release through two flops, so release is clean against clk_sys
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Counter clock and gate are synchronous inputs; edges found by comparison
	assign rise_ev = ctr_clk & ~ctr_q;
	assign fall_ev = ~ctr_clk & ctr_q;
	assign gate_rise = gate & ~gate_q;
	assign count_done = (bytes_sel == BYTES_LSB && lsb_wr) ||
		(bytes_sel == BYTES_MSB && msb_wr) ||
		(bytes_sel == BYTES_BOTH && msb_wr && lsb_pending);

	// Edge trackers and gate sampling on the counter clock rise
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctr_q <= 1'b0;
			gate_q <= 1'b0;
			gate_s <= 1'b0;
			trig_ff <= 1'b0;
			trig_s <= 1'b0;
		end
		else if (clk_en)
		begin
			ctr_q <= ctr_clk;
			gate_q <= gate;
			if (rise_ev)
			begin
				gate_s <= gate; // R23
				trig_s <= trig_ff; // R23
				trig_ff <= 1'b0;
			end
			// A gate edge in the sampling cycle wins over the clear
			if (gate_rise)
				trig_ff <= 1'b1; // R23
			if (ctrl_wr)
				trig_ff <= 1'b0;
		end
	end

	// Control word and count byte capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_mode <= MODE_TERM;
			bcd_sel <= 1'b0;
			bytes_sel <= BYTES_LSB;
			count_holding_register <= COUNT_RESET;
			lsb_pending <= 1'b0;
			have_count <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ctrl_wr)
			begin
				// Codes 6 and 7 alias the periodic modes
				cnt_mode <= (mode_in[2:1] == 2'b11) ? {1'b0, mode_in[1:0]} : mode_in; // R27
				bcd_sel <= bcd_in;
				bytes_sel <= bytes_in;
				lsb_pending <= 1'b0;
				have_count <= 1'b0;
			end
			else
			begin
				if (lsb_wr)
				begin
					count_holding_register[7:0] <= wr_data;
					if (bytes_sel == BYTES_LSB)
						count_holding_register[15:8] <= 8'h00;
					lsb_pending <= (bytes_sel == BYTES_BOTH);
				end
				if (msb_wr)
				begin
					count_holding_register[15:8] <= wr_data;
					if (bytes_sel == BYTES_MSB)
						count_holding_register[7:0] <= 8'h00;
					lsb_pending <= 1'b0;
				end
				if (count_done)
					have_count <= 1'b1;
			end
		end
	end

	// Counting element and output; every load and step waits for a fall
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ce <= COUNT_RESET;
			timer_out <= OUT_RESET;
			load_pending <= 1'b0;
			counting <= 1'b0;
			halt <= 1'b0;
			wrapped <= 1'b0;
			fired <= 1'b0;
			odd_wait <= 1'b0;
		end
		else if (clk_en)
		begin
			if (ctrl_wr)
			begin
				timer_out <= (mode_in == MODE_TERM) ? 1'b0 : 1'b1; // R26 R1
				load_pending <= 1'b0;
				counting <= 1'b0;
				halt <= 1'b0;
				wrapped <= 1'b0;
				fired <= 1'b0;
				odd_wait <= 1'b0;
			end
			else
			begin
				if (fall_ev) // R24
				begin
					unique case (cnt_mode)
						MODE_TERM:
						begin
							if (load_pending)
							begin
								ce <= count_holding_register; // R3 R6
								load_pending <= 1'b0;
								counting <= 1'b1;
								halt <= 1'b0;
								wrapped <= 1'b0;
							end
							else if (counting && gate_s && !halt) // R2
							begin
								ce <= icm_dec(ce, bcd_sel); // R25
								if (ce == COUNT_ZERO)
									wrapped <= 1'b1;
								if (ce == COUNT_ONE)
									timer_out <= 1'b1; // R1
							end
						end
						MODE_ONESHOT:
						begin
							if (trig_s && have_count)
							begin
								ce <= count_holding_register; // R8 R9
								timer_out <= 1'b0; // R7
								counting <= 1'b1;
								load_pending <= 1'b0;
							end
							else if (counting)
							begin
								ce <= icm_dec(ce, bcd_sel); // R25
								if (ce == COUNT_ONE)
									timer_out <= 1'b1; // R7
							end
						end
						MODE_RATE:
						begin
							if ((trig_s && have_count) || (load_pending && !counting))
							begin
								ce <= count_holding_register; // R10 R12
								timer_out <= 1'b1;
								counting <= 1'b1;
								load_pending <= 1'b0;
							end
							else if (counting && gate_s) // R2
							begin
								if (ce == COUNT_ONE)
								begin
									ce <= count_holding_register; // R13 R25
									timer_out <= 1'b1;
									load_pending <= 1'b0;
								end
								else
								begin
									ce <= icm_dec(ce, bcd_sel);
									if (ce == COUNT_TWO)
										timer_out <= 1'b0; // R10
								end
							end
						end
						MODE_SQUARE:
						begin
							if ((trig_s && have_count) || (load_pending && !counting))
							begin
								ce <= count_holding_register & EVEN_MASK; // R12 R17
								timer_out <= 1'b1;
								counting <= 1'b1;
								load_pending <= 1'b0;
								odd_wait <= 1'b0;
							end
							else if (counting && gate_s) // R2
							begin
								if (odd_wait || ce == COUNT_TWO)
								begin
									// Odd counts hold high one extra pulse after expiry
									if (timer_out && count_holding_register[0] && !odd_wait)
										odd_wait <= 1'b1; // R17
									else
									begin
										timer_out <= ~timer_out; // R15 R16
										ce <= count_holding_register & EVEN_MASK; // R18
										odd_wait <= 1'b0;
										load_pending <= 1'b0;
									end
								end
								else
									ce <= icm_dec(icm_dec(ce, bcd_sel), bcd_sel); // R16
							end
						end
						MODE_SWSTROBE:
						begin
							if (load_pending)
							begin
								ce <= count_holding_register; // R19 R20
								load_pending <= 1'b0;
								counting <= 1'b1;
								fired <= 1'b0;
								timer_out <= 1'b1;
							end
							else
							begin
								if (!timer_out)
									timer_out <= 1'b1;
								if (counting && gate_s) // R2
								begin
									ce <= icm_dec(ce, bcd_sel); // R25
									if (ce == COUNT_ONE && !fired)
									begin
										timer_out <= 1'b0; // R19
										fired <= 1'b1;
									end
								end
							end
						end
						MODE_HWSTROBE:
						begin
							if (trig_s && have_count)
							begin
								ce <= count_holding_register; // R21 R22
								load_pending <= 1'b0;
								counting <= 1'b1;
								fired <= 1'b0;
								timer_out <= 1'b1;
							end
							else
							begin
								if (!timer_out)
									timer_out <= 1'b1;
								if (counting)
								begin
									ce <= icm_dec(ce, bcd_sel); // R25
									if (ce == COUNT_ONE && !fired)
									begin
										timer_out <= 1'b0; // R21
										fired <= 1'b1;
									end
								end
							end
						end
						default:
						begin
							counting <= 1'b0;
						end
					endcase
				end
				// Byte writes come after the fall so a new count is never lost
				if (count_done)
					load_pending <= 1'b1;
				if (cnt_mode == MODE_TERM && (lsb_wr || msb_wr))
					timer_out <= 1'b0; // R4 R1
				if (cnt_mode == MODE_TERM && lsb_wr && bytes_sel == BYTES_BOTH && counting &&
					!wrapped)
					halt <= 1'b1; // R5
				// Gate low ends a low phase at once in periodic modes
				if ((cnt_mode == MODE_RATE || cnt_mode == MODE_SQUARE) && !gate)
					timer_out <= 1'b1; // R11
			end
		end
	end

	assign count_value = ce;
	assign null_count = load_pending;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence seq_cw_term;
		clk_en && ctrl_wr && mode_in == MODE_TERM;
	endsequence
	sequence seq_sw_load;
		clk_en && !ctrl_wr && fall_ev && load_pending && !count_done && cnt_mode == MODE_SWSTROBE;
	endsequence

	AST_CW_TERM_LOW: assert property (seq_cw_term |=> !timer_out) // R26
		else $error("control word for mode 0 did not drive output low");
	AST_CW_OTHER_HIGH: assert property (clk_en && ctrl_wr && mode_in != MODE_TERM // R26
		|=> timer_out)
		else $error("control word did not drive output high");
	AST_TERM_BYTE_LOW: assert property (clk_en && !ctrl_wr && cnt_mode == MODE_TERM && lsb_wr // R4
		|=> !timer_out)
		else $error("mode 0 byte write left output high");
	AST_SW_LOAD: assert property (seq_sw_load |=> ce == $past(count_holding_register)) // R19
		else $error("mode 4 count not loaded on fall");
	AST_TERM_GATE_HOLD: assert property (clk_en && !ctrl_wr && fall_ev && // R2
		cnt_mode == MODE_TERM && !gate_s && !load_pending |=> $stable(ce))
		else $error("mode 0 counted with gate low");
	AST_PERIODIC_GATE_HIGH: assert property (clk_en && !ctrl_wr && !gate && // R11
		(cnt_mode == MODE_RATE || cnt_mode == MODE_SQUARE) |=> timer_out)
		else $error("gate low did not force output high");
	AST_SQUARE_STEP: assert property (clk_en && !ctrl_wr && fall_ev && // R16
		cnt_mode == MODE_SQUARE && counting && gate_s && gate && !trig_s && !load_pending &&
		!odd_wait && ce != COUNT_TWO && !bcd_sel |=> ce == $past(ce) - COUNT_TWO)
		else $error("mode 3 did not step by two");
	AST_STROBE_ONE_PULSE: assert property (clk_en && !ctrl_wr && fall_ev && !timer_out && // R19
		(cnt_mode == MODE_SWSTROBE || cnt_mode == MODE_HWSTROBE) |=> timer_out)
		else $error("strobe lasted longer than one pulse");
	AST_TRIG_CATCH: assert property (clk_en && !ctrl_wr && gate_rise |=> trig_ff) // R23
		else $error("gate rise not caught");
	AST_TRIG_SAMPLE: assert property (clk_en && rise_ev && !ctrl_wr && trig_ff ##1 clk_en // R23
		|-> trig_s)
		else $error("trigger flag not sampled on rise");
endmodule : icm_channel
`default_nettype wire

/* hw/icm_pkg.sv */
package icm_pkg;
	// Counting modes as held by the channel
	localparam logic [2:0] MODE_TERM = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTROBE = 3'h4;
	localparam logic [2:0] MODE_HWSTROBE = 3'h5;
	// Byte access settings
	localparam logic [1:0] BYTES_LSB = 2'h1;
	localparam logic [1:0] BYTES_MSB = 2'h2;
	localparam logic [1:0] BYTES_BOTH = 2'h3;
	// Reset values and count constants
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] EVEN_MASK = 16'hFFFE;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [15:0] COUNT_TWO = 16'h0002;
	localparam logic [15:0] COUNT_ZERO = 16'h0000;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic OUT_RESET = 1'b1;
	// System clock period in ns
	localparam int CLK_PERIOD_NS = 25;
endpackage : icm_pkg

/* tb/icm_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host bus and control-word logic in front of one channel
module icm_host_model
(
	input wire logic clk_sys,
	output logic ctrl_wr,
	output logic [2:0] mode_in,
	output logic bcd_in,
	output logic [1:0] bytes_in,
	output logic lsb_wr,
	output logic msb_wr,
	output logic [7:0] wr_data
);
	import icm_pkg::*;
	// Idle bus at time zero
	initial
	begin
		ctrl_wr = 1'b0;
		mode_in = MODE_TERM;
		bcd_in = 1'b0;
		bytes_in = BYTES_LSB;
		lsb_wr = 1'b0;
		msb_wr = 1'b0;
		wr_data = 8'h00;
	end
	// Mode and byte access travel with the one-cycle control strobe
	task automatic put_ctrl(input logic [2:0] mode, input logic [1:0] bytes, input logic bcd);
		@(negedge clk_sys);
		mode_in = mode;
		bytes_in = bytes;
		bcd_in = bcd;
		ctrl_wr = 1'b1;
		@(negedge clk_sys);
		ctrl_wr = 1'b0;
	endtask : put_ctrl
	// One count byte per strobe; data is inverted once released so stale values never match
	task automatic put_byte(input logic hi, input logic [7:0] data);
		@(negedge clk_sys);
		wr_data = data;
		lsb_wr = ~hi;
		msb_wr = hi;
		@(negedge clk_sys);
		lsb_wr = 1'b0;
		msb_wr = 1'b0;
		wr_data = ~data;
	endtask : put_byte
endmodule : icm_host_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import icm_pkg::*;
	logic clk_sys, reset_n, ctr_clk, gate, clk_en;
	logic ctrl_wr, bcd_in, lsb_wr, msb_wr, timer_out, null_count;
	logic [2:0] mode_in;
	logic [1:0] bytes_in;
	logic [7:0] wr_data;
	logic [15:0] count_value;
	int num_errors = 0;
	int samples_checked = 0;
	logic [31:0] rnd_state = 32'h0000002D;

	icm_host_model host_u (.clk_sys(clk_sys), .ctrl_wr(ctrl_wr), .mode_in(mode_in),
		.bcd_in(bcd_in), .bytes_in(bytes_in), .lsb_wr(lsb_wr), .msb_wr(msb_wr),
		.wr_data(wr_data));
	icm_channel dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
		.ctr_clk(ctr_clk), .gate(gate), .ctrl_wr(ctrl_wr), .mode_in(mode_in),
		.bcd_in(bcd_in), .bytes_in(bytes_in), .lsb_wr(lsb_wr), .msb_wr(msb_wr),
		.wr_data(wr_data), .timer_out(timer_out), .count_value(count_value),
		.null_count(null_count));

	// System clock
	initial
	begin
		clk_sys = 1'b0;
		forever #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] next_rand();
		rnd_state ^= rnd_state << 13;
		rnd_state ^= rnd_state >> 17;
		rnd_state ^= rnd_state << 5;
		return rnd_state;
	endfunction : next_rand

	task automatic report_and_stop();
		$display("checks made %0d, mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic settle(input int c);
		repeat (c) @(negedge clk_sys);
	endtask : settle

	// One counter clock pulse, each level held several system cycles
	task automatic pulse();
		@(negedge clk_sys);
		ctr_clk = 1'b1;
		settle(2);
		ctr_clk = 1'b0;
		settle(3);
	endtask : pulse

	// Reference counting element at pulse k, counted from the load pulse (k = 1 is the load)
	function automatic int ref_ce(logic [2:0] m, int n, int k);
		if (m == MODE_RATE)
			return n - ((k - 1) % n);
		return (n - (k - 1)) & 32'h0000FFFF;
	endfunction : ref_ce

	function automatic logic ref_out(logic [2:0] m, int n, int k);
		case (m)
			MODE_TERM, MODE_ONESHOT: return k > n;
			MODE_RATE: return (k % n) != 0;
			default: return k != n + 1;
		endcase
	endfunction : ref_out

	// Program a mode and count, then step pulses comparing against the reference
	task automatic run(input logic [2:0] m, input int n, input logic [1:0] bytes, input int hold);
		int highs;
		int np;
		logic trig;
		int exp_n;
		highs = 0;
		trig = (m == MODE_ONESHOT) || (m == MODE_HWSTROBE);
		np = (m == MODE_SQUARE || m == MODE_RATE) ? 2 * n : n + 2;
		gate = ~trig;
		host_u.put_ctrl(m, bytes, 1'b0);
		settle(2);
		chk("out after control word", {15'h0000, m != MODE_TERM}, {15'h0000, timer_out});
		host_u.put_byte(1'b0, n[7:0]);
		if (bytes == BYTES_BOTH)
			host_u.put_byte(1'b1, 8'h00);
		settle(2);
		chk("null count after write", 16'h0001, {15'h0000, null_count});
		if (trig)
		begin
			pulse();
			chk("count kept without trigger", 16'h0001, {15'h0000, null_count});
			gate = 1'b1;
		end
		for (int k = 1; k <= np; k++)
		begin
			pulse();
			highs += timer_out;
			if (m != MODE_SQUARE)
				chk("count value", 16'(ref_ce(m, n, k)), count_value);
			if (m != MODE_SQUARE)
				chk("timer out", {15'h0000, ref_out(m, n, k)}, {15'h0000, timer_out});
			if (k == 1)
				chk("null count after load", 16'h0000, {15'h0000, null_count});
			if (k == 1 && hold > 0)
			begin
				gate = 1'b0;
				repeat (hold) pulse();
				chk("count with gate low", 16'(n), count_value);
				chk("out with gate low", {15'h0000, m != MODE_TERM}, {15'h0000, timer_out});
				gate = 1'b1;
			end
		end
		if (m == MODE_SQUARE)
			chk("high pulses", 16'(n + n % 2), 16'(highs));
		if (m == MODE_RATE)
		begin
			gate = 1'b0;
			settle(2);
			chk("out forced high by gate", 16'h0001, {15'h0000, timer_out});
		end
		// A fresh trigger reloads the held count; square mode drops the odd bit
		if (m != MODE_TERM && m != MODE_SWSTROBE)
		begin
			exp_n = (m == MODE_SQUARE) ? n - n % 2 : n;
			gate = 1'b0;
			pulse();
			gate = 1'b1;
			pulse();
			chk("count after retrigger", 16'(exp_n), count_value);
			chk("out after retrigger", {15'h0000, m != MODE_ONESHOT}, {15'h0000, timer_out});
		end
	endtask : run

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		report_and_stop();
	end

	// Main sequence; counts stay at two or more in the periodic modes
	initial
	begin
		int n;
		reset_n = 1'b0;
		clk_en = 1'b1;
		ctr_clk = 1'b0;
		gate = 1'b0;
		settle(2);
		reset_n = 1'b1;
		settle(4);
		n = 3 + int'(next_rand() % 6);
		run(MODE_TERM, n, BYTES_LSB, 2);
		run(MODE_TERM, n + 1, BYTES_BOTH, 0);
		host_u.put_byte(1'b0, 8'h05);
		settle(1);
		chk("out after first byte", 16'h0000, {15'h0000, timer_out});
		// Enable low must swallow a whole counter pulse
		clk_en = 1'b0;
		pulse();
		chk("count frozen by enable", 16'(ref_ce(MODE_TERM, n + 1, n + 3)), count_value);
		clk_en = 1'b1;
		pulse();
		chk("count after low byte past wrap", 16'(ref_ce(MODE_TERM, n + 1, n + 4)), count_value);
		// Low byte before any wrap halts the count until the high byte lands
		host_u.put_byte(1'b1, 8'h00);
		pulse();
		pulse();
		host_u.put_byte(1'b0, 8'h07);
		pulse();
		chk("count halted by low byte", 16'h0004, count_value);
		host_u.put_byte(1'b1, 8'h00);
		pulse();
		chk("count after second byte", 16'h0007, count_value);
		// Decimal counting with a high-byte-only count borrows across digits
		host_u.put_ctrl(MODE_TERM, BYTES_MSB, 1'b1);
		host_u.put_byte(1'b1, 8'h01);
		pulse();
		chk("decimal count loaded", 16'h0100, count_value);
		pulse();
		chk("decimal count step", 16'h0099, count_value);
		run(MODE_SWSTROBE, 3 + int'(next_rand() % 6), BYTES_LSB, 2);
		run(MODE_RATE, 3 + int'(next_rand() % 6), BYTES_LSB, 0);
		n = 4 + 2 * int'(next_rand() % 3);
		run(MODE_SQUARE, n, BYTES_LSB, 0);
		run(MODE_SQUARE, n + 1, BYTES_LSB, 0);
		run(MODE_ONESHOT, 3 + int'(next_rand() % 6), BYTES_LSB, 0);
		run(MODE_HWSTROBE, 3 + int'(next_rand() % 6), BYTES_LSB, 0);
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
